// ---- hw/sucs_defines.svh ----
`ifndef SUCS_DEFINES_SVH
`define SUCS_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SUCS_OFS_CLOCK_GATE 8'h00
`define SUCS_OFS_PRESCALE 8'h04
`define SUCS_OFS_STOP_TRIG 8'h08
`define SUCS_OFS_MASK_HIGH 8'h0C
`define SUCS_OFS_REQ_HIGH 8'h10
`define SUCS_OFS_START_TRIG 8'h14
`define SUCS_OFS_CHAN0_MODE 8'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SUCS_GATE_BIT 2
`define SUCS_PRS_A_LSB 0
`define SUCS_PRS_B_LSB 4
`define SUCS_PRS_W 4
`define SUCS_NUM_CHAN 4
`define SUCS_CHAN0_IRQ_BIT 5
`define SUCS_MODE_LSB 1
`define SUCS_MODE_W 2

// ------------------------------------------------------------
// Reset values and fixed bits
// ------------------------------------------------------------
`define SUCS_GATE_RST 8'h00
`define SUCS_PRESCALE_RST 16'h0000
`define SUCS_MASK_RST 8'hFF
`define SUCS_REQ_RST 8'h00
`define SUCS_MASK_FIXED1 8'h18
`define SUCS_REQ_FIXED0 8'h18
`define SUCS_ERR_DATA 32'h00000000

`endif

// ---- hw/sucs_pkg.sv ----
package sucs_pkg;

  // Channel operating mode codes
  typedef enum logic [1:0] {
    SUCS_MODE_CLOCKED = 2'h0,
    SUCS_MODE_ASYNC = 2'h1,
    SUCS_MODE_TWO_WIRE = 2'h2,
    SUCS_MODE_PROHIBITED = 2'h3
  } sucs_mode_t;

  typedef logic [3:0] sucs_prs_t;

endpackage

// ---- hw/sucs_tick_if.sv ----
`timescale 1ns/1ps
interface sucs_tick_if;
  logic run;
  sucs_pkg::sucs_prs_t sel_a;
  sucs_pkg::sucs_prs_t sel_b;
  logic tick_a;
  logic tick_b;

  modport ctrl (output run, output sel_a, output sel_b,
                input tick_a, input tick_b);
  modport div (input run, input sel_a, input sel_b,
               output tick_a, output tick_b);
endinterface

// ---- hw/sucs_prescale.sv ----
`timescale 1ns/1ps
module sucs_prescale #(
  parameter int CNT_W = 15
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and ticks
  sucs_tick_if.div tk
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask_a;
  logic [CNT_W-1:0] mask_b;

  // Divide by two to the field: tick when low field bits are all ones
  assign mask_a = CNT_W'((32'h1 << tk.sel_a) - 32'h1);
  assign mask_b = CNT_W'((32'h1 << tk.sel_b) - 32'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!tk.run) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tk.tick_a <= 1'b0;
      tk.tick_b <= 1'b0;
    end else begin
      tk.tick_a <= tk.run && ((cnt_q & mask_a) == mask_a);
      tk.tick_b <= tk.run && ((cnt_q & mask_b) == mask_b);
    end
  end

endmodule

// ---- hw/sucs_ctrl.sv ----
`timescale 1ns/1ps
`include "sucs_defines.svh"
module sucs_ctrl #(
  parameter int NUM_CHAN = `SUCS_NUM_CHAN
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources from the interrupt request register bits
  input wire logic [7:0] irq_event,
  // Serial unit control
  output logic unit_clk_en,
  output logic unit_rst_n,
  output logic [NUM_CHAN-1:0] chan_enable,
  output logic [1:0] chan0_op_mode,
  output logic operating_clock_a,
  output logic operating_clock_b,
  // Interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] gate_q;
  logic [15:0] prs_q;
  logic [7:0] mask_q;
  logic [7:0] req_q;
  logic [NUM_CHAN-1:0] en_q;
  sucs_pkg::sucs_mode_t mode_q;
  logic ready_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic irq_q;
  logic unit_on_q;
  logic unit_rst_n_q;
  logic tick_a_q;
  logic tick_b_q;

  logic access;
  logic wr;
  logic unit_on;
  logic unit_wr;
  logic mapped;
  logic [31:0] rd_mux;
  logic [7:0] req_d;
  sucs_pkg::sucs_mode_t new_mode;

  sucs_tick_if tk ();

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // One wait state: pready rises the cycle after the access phase begins
  assign access = psel && penable && !ready_q;
  assign wr = psel && penable && ready_q && pwrite;
  assign unit_on = gate_q[`SUCS_GATE_BIT];
  assign unit_wr = wr && unit_on;
  assign new_mode = sucs_pkg::sucs_mode_t'(
    pwdata[`SUCS_MODE_LSB +: `SUCS_MODE_W]);

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr)
      `SUCS_OFS_CLOCK_GATE: rd_mux = {24'h000000, gate_q};
      `SUCS_OFS_PRESCALE: rd_mux = {16'h0000, prs_q};
      // The write-only stop trigger reads as zero; the start trigger reads back the enables
      `SUCS_OFS_STOP_TRIG: rd_mux = 32'h00000000;
      `SUCS_OFS_MASK_HIGH: rd_mux = {24'h000000, mask_q};
      `SUCS_OFS_REQ_HIGH: rd_mux = {24'h000000, req_q};
      `SUCS_OFS_START_TRIG: rd_mux = 32'(en_q);
      `SUCS_OFS_CHAN0_MODE:
        rd_mux = 32'({mode_q, 1'b0});
      default: mapped = 1'b0;
    endcase
  end

  // Answer one cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= access;
    end
  end

  // Unmapped offsets answer with an error and zero data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= access && !mapped;
    end
  end

  // Captured once, so it stands while pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= `SUCS_ERR_DATA;
    end else if (access) begin
      rdata_q <= mapped ? rd_mux : `SUCS_ERR_DATA;
    end
  end

  // ------------------------------------------------------------
  // Clock gate register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= `SUCS_GATE_RST;
    end else if (wr && paddr == `SUCS_OFS_CLOCK_GATE) begin
      gate_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_on_q <= 1'b0;
    end else begin
      unit_on_q <= unit_on;
    end
  end

  // unit reset while gated
  // Drops with the clock so the unit never runs half configured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_rst_n_q <= 1'b0;
    end else begin
      unit_rst_n_q <= unit_on;
    end
  end

  // ------------------------------------------------------------
  // Prescaler select
  // ------------------------------------------------------------
  // unit registers cleared while gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prs_q <= `SUCS_PRESCALE_RST;
    end else if (!unit_on) begin
      prs_q <= `SUCS_PRESCALE_RST;
    end else if (unit_wr && paddr == `SUCS_OFS_PRESCALE) begin
      // Upper byte is fixed at zero
      prs_q <= {8'h00, pwdata[7:0]};
    end
  end

  assign tk.run = unit_on;
  assign tk.sel_a = prs_q[`SUCS_PRS_A_LSB +: `SUCS_PRS_W];
  assign tk.sel_b = prs_q[`SUCS_PRS_B_LSB +: `SUCS_PRS_W];

  sucs_prescale #(
    .CNT_W(15)
  ) u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );

  // ------------------------------------------------------------
  // Operating clock outputs
  // ------------------------------------------------------------
  // Extra stage keeps the top outputs straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_a_q <= 1'b0;
    end else begin
      tick_a_q <= tk.tick_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_b_q <= 1'b0;
    end else begin
      tick_b_q <= tk.tick_b;
    end
  end

  // ------------------------------------------------------------
  // Channel start and stop
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
    end else if (!unit_on) begin
      en_q <= '0;
    end else if (unit_wr && paddr == `SUCS_OFS_STOP_TRIG) begin
      en_q <= en_q & ~pwdata[NUM_CHAN-1:0];
    end else if (unit_wr && paddr == `SUCS_OFS_START_TRIG) begin
      en_q <= en_q | pwdata[NUM_CHAN-1:0];
    end
  end

  // ------------------------------------------------------------
  // Channel 0 operating mode
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= sucs_pkg::SUCS_MODE_CLOCKED;
    end else if (!unit_on) begin
      mode_q <= sucs_pkg::SUCS_MODE_CLOCKED;
    end else if (unit_wr && paddr == `SUCS_OFS_CHAN0_MODE) begin
      if (new_mode != sucs_pkg::SUCS_MODE_PROHIBITED) begin
        mode_q <= new_mode;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt mask and request
  // ------------------------------------------------------------
  // mask one disables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `SUCS_MASK_RST;
    end else if (wr && paddr == `SUCS_OFS_MASK_HIGH) begin
      mask_q <= pwdata[7:0] | `SUCS_MASK_FIXED1;
    end
  end

  // Write zero clears; a new request in the same cycle still wins
  always_comb begin
    req_d = req_q;
    if (wr && paddr == `SUCS_OFS_REQ_HIGH) begin
      req_d = req_q & pwdata[7:0];
    end
    req_d = (req_d | irq_event) & ~`SUCS_REQ_FIXED0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= `SUCS_REQ_RST;
    end else begin
      req_q <= req_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(req_q & ~mask_q);
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign irq = irq_q;
  assign unit_clk_en = unit_on_q;
  assign unit_rst_n = unit_rst_n_q;
  assign chan_enable = en_q;
  assign chan0_op_mode = mode_q;
  assign operating_clock_a = tick_a_q;
  assign operating_clock_b = tick_b_q;

endmodule

// ---- sim/sucs_ctrl_monitor.sv ----
`timescale 1ns/1ps
`include "sucs_defines.svh"
module sucs_ctrl_monitor #(
  parameter int NUM_CHAN = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Unit control
  input wire logic unit_clk_en,
  input wire logic unit_rst_n,
  input wire logic [NUM_CHAN-1:0] chan_enable,
  input wire logic [1:0] chan0_op_mode,
  input wire logic operating_clock_a,
  input wire logic operating_clock_b
);
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Completed writes
  // ----------------------------------------
  logic wr;
  logic wr_start;
  logic wr_stop;
  logic wr_gate;
  assign wr = psel && penable && pready && pwrite;
  assign wr_gate = wr && paddr == `SUCS_OFS_CLOCK_GATE;
  assign wr_start = wr && paddr == `SUCS_OFS_START_TRIG && pwdata[0];
  assign wr_stop = wr && paddr == `SUCS_OFS_STOP_TRIG;
  chk_rst_with_gate: assert property (
    unit_rst_n == unit_clk_en) else $error("reset not tied to gate");
  chk_gate_follow: assert property (
    wr_gate |-> ##2 unit_clk_en == $past(pwdata[`SUCS_GATE_BIT], 2))
    else $error("clock gate did not follow write");
  chk_gate_idle: assert property (
    !unit_clk_en [*3] |-> chan_enable == '0 && chan0_op_mode == 2'h0
    && !operating_clock_a && !operating_clock_b)
    else $error("unit active while gated");
  chk_ready_slot: assert property (
    psel && !penable |=> !pready ##1 pready ##1 !pready)
    else $error("pready out of slot");
  chk_err_zero: assert property (
    pslverr |-> pready && prdata == '0) else $error("bad error answer");
  chk_stop_clears: assert property (
    wr_stop && pwdata[0] |-> ##[1:2] !chan_enable[0])
    else $error("stop did not clear");
  chk_stop_zero: assert property (
    wr_stop && pwdata[3:0] == 4'h0 |=> $stable(chan_enable))
    else $error("zero stop changed enable");
  chk_start_only: assert property (
    $rose(chan_enable[0]) |-> $past(wr_start) || $past(wr_start, 2))
    else $error("enable set without start");
  chk_mode_legal: assert property (
    chan0_op_mode != 2'h3) else $error("prohibited mode taken");
  cover property (wr_stop && pwdata[0]);
  cover property ($rose(unit_clk_en));
  cover property (pslverr);
endmodule

bind sucs_ctrl sucs_ctrl_monitor #(.NUM_CHAN(NUM_CHAN)) mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .unit_clk_en, .unit_rst_n, .chan_enable,
  .chan0_op_mode, .operating_clock_a, .operating_clock_b);

// ---- sim/sucs_apb_host.sv ----
`timescale 1ns/1ps
module sucs_apb_host (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- sim/serial_unit_clock_stop_irq_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`include "sucs_defines.svh"
module serial_unit_clock_stop_irq_ctrl_tb_top;
  localparam logic [7:0] a_st = `SUCS_OFS_START_TRIG;
  localparam logic [7:0] a_sp = `SUCS_OFS_STOP_TRIG;
  localparam logic [7:0] a_rq = `SUCS_OFS_REQ_HIGH;
  localparam logic [7:0] a_ps = `SUCS_OFS_PRESCALE;
  localparam logic [7:0] a_mk = `SUCS_OFS_MASK_HIGH;
  localparam logic [7:0] a_gt = `SUCS_OFS_CLOCK_GATE;
  localparam int limit = 6000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] irq_event = 8'h00;
  logic unit_clk_en, unit_rst_n, operating_clock_a, operating_clock_b;
  logic [3:0] chan_enable;
  logic [1:0] chan0_op_mode;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2.5 pclk = ~pclk;
  sucs_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_event, .unit_clk_en,
    .unit_rst_n, .chan_enable, .chan0_op_mode, .operating_clock_a,
    .operating_clock_b, .irq);
  sucs_apb_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == limit) begin
      mismatches++;
      summarize();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    host.xfer(w, a, d, r, e);
    cmp({31'h0, e}, {31'h0, a > 8'h18});
    if (!w) cmp(r, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xf(1'b0, a, 32'h0, x);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_gated();
    rd(a_mk, 32'hFF);
    rd(a_rq, 32'h0);
    wr(a_ps, 32'h44);
    wr(a_st, 32'h1);
    rd(a_ps, 32'h0);
    rd(a_st, 32'h0);
    cmp({30'h0, unit_clk_en, unit_rst_n}, 32'h0);
    wr(a_gt, 32'h4);
    settle();
    cmp({30'h0, unit_clk_en, unit_rst_n}, 32'h3);
  endtask
  task automatic pulse(input logic b);
    do @(posedge pclk);
    while ((b ? operating_clock_b : operating_clock_a) !== 1'b1
           && cyc < limit);
  endtask
  task automatic t_div(input logic [3:0] f, input logic [3:0] g);
    int t0;
    wr(a_ps, {16'h0000, 8'hFF, g, f});
    rd(a_ps, {24'h0, g, f});
    pulse(1'b0);
    pulse(1'b0);
    t0 = cyc;
    pulse(1'b0);
    cmp(32'(cyc - t0), 32'h1 << f);
    pulse(1'b1);
    pulse(1'b1);
    t0 = cyc;
    pulse(1'b1);
    cmp(32'(cyc - t0), 32'h1 << g);
  endtask
  task automatic t_stop();
    wr(a_st, 32'hF);
    rd(a_st, 32'hF);
    wr(a_sp, 32'hFFF0);
    rd(a_st, 32'hF);
    wr(a_sp, 32'h5);
    rd(a_st, 32'hA);
    rd(a_sp, 32'h0);
    cmp({28'h0, chan_enable}, 32'hA);
  endtask
  task automatic t_irq();
    wr(a_sp, 32'h1);
    wr(a_mk, 32'hFF);
    wr(a_rq, 32'h0);
    irq_event <= 8'h38;
    @(posedge pclk);
    irq_event <= 8'h00;
    rd(a_rq, 32'h20);
    cmp({31'h0, irq}, 32'h0);
    wr(a_mk, 32'hDF);
    settle();
    cmp({31'h0, irq}, 32'h1);
    wr(a_rq, 32'hFF);
    rd(a_rq, 32'h20);
    wr(a_rq, 32'h0);
    settle();
    cmp({31'h0, irq}, 32'h0);
  endtask
  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      wr(`SUCS_OFS_CHAN0_MODE, 32'(m << 1));
      settle();
      cmp({30'h0, chan0_op_mode}, (m == 3) ? 32'h2 : 32'(m));
    end
    wr(8'h40, 32'h1);
    rd(8'h40, 32'h0);
    wr(a_gt, 32'h0);
    settle();
    cmp({26'h0, chan_enable, chan0_op_mode}, 32'h0);
    wr(a_gt, 32'h4);
    rd(a_st, 32'h0);
    rd(a_ps, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_gated();
    t_div(4'h0, 4'h1);
    t_div(4'h1, 4'h0);
    t_div(4'h4, 4'h5);
    t_stop();
    t_irq();
    t_mode();
    summarize();
  end
endmodule
